// file: logic/zqodt_pkg.sv
// constants, register map and types for the zq calibration and odt control block
package zqodt_pkg;
   // ==========================================
   // register map (byte addresses)
   localparam logic [7:0] MODE_OFS = 8'h00;
   localparam logic [7:0] LAT_OFS = 8'h04;
   localparam logic [7:0] STAT_OFS = 8'h08;

   // ==========================================
   // mode register fields
   localparam int MODE_NOM_A2 = 0;
   localparam int MODE_NOM_A6 = 1;
   localparam int MODE_NOM_A9 = 2;
   localparam int MODE_WR_A9 = 3;
   localparam int MODE_WR_A10 = 4;
   localparam int MODE_TDQS_A11 = 5;
   localparam int MODE_PPD_A12 = 6;
   localparam int MODE_W = 7;
   localparam logic [6:0] MODE_RST = 7'h00;

   // ==========================================
   // latency register fields
   localparam int LAT_CWL_LSB = 0;
   localparam int LAT_AL_LSB = 4;
   localparam int LAT_FLD_W = 4;
   localparam logic [3:0] CWL_RST = 4'h5;
   localparam logic [3:0] AL_RST = 4'h0;
   localparam logic [4:0] ODTL_OFFSET = 5'h02;

   // ==========================================
   // status register fields
   localparam int STAT_BUSY = 0;
   localparam int STAT_FIRST = 1;
   localparam int STAT_TERM = 2;
   localparam int STAT_SYNC = 3;
   localparam int STAT_LONG = 4;
   localparam int STAT_CODE_LSB = 8;

   // ==========================================
   // calibration timing, in ck cycles
   localparam int ZQINIT_NCK = 512;
   localparam int ZQOPER_NCK = 256;
   localparam int ZQCS_NCK = 64;
   localparam int ZQ_CNT_W = 10;

   // ==========================================
   // impedance code
   localparam int CODE_W = 6;
   localparam logic [5:0] CODE_RST = 6'h20;
   localparam logic [5:0] CODE_MAX = 6'h3f;
   localparam int ODT_DEPTH = 32;
   localparam int TAP_W = 5;

   typedef enum logic [1:0] {
      ZQ_IDLE = 2'b00,
      ZQ_LONG = 2'b01,
      ZQ_SHORT = 2'b10
   } zqodt_cal_t;
endpackage

// file: logic/zqodt_sync.sv
// two flip-flop synchroniser for pins entering the clk_in domain
module zqodt_sync #(
   parameter int W = 1
) (
   input wire logic clk_in, // system clock
   input wire logic rst_in, // async reset, high
   input wire logic [W-1:0] d_in, // asynchronous inputs
   output logic [W-1:0] q_out // synchronised outputs
);
   logic [W-1:0] meta_reg;

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         meta_reg <= '0;
         q_out <= '0;
      end else begin
         meta_reg <= d_in;
         q_out <= meta_reg;
      end
   end
endmodule

// file: logic/zqodt_dline.sv
// odt delay line stepped once per ck rising edge, with selectable tap
module zqodt_dline #(
   parameter int DEPTH = 32,
   parameter int TW = 5
) (
   input wire logic clk_in, // system clock
   input wire logic rst_in, // async reset, high
   input wire logic step_in, // ck rising edge pulse
   input wire logic d_in, // odt as registered at the edge
   input wire logic [TW-1:0] tap_in, // delay in ck cycles
   output logic q_out // delayed odt
);
   logic [DEPTH-1:0] line_reg;

   // line_reg[i] holds the value registered i edges ago
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         line_reg <= '0;
      end else if (step_in) begin
         line_reg <= {line_reg[DEPTH-2:0], d_in};
      end
   end

   assign q_out = line_reg[tap_in];
endmodule

// file: logic/zqodt_ctrl.sv
// zq calibration engine and synchronous on-die termination control with apb registers
// What this block does and what its controller must do
// [RULE1] long calibration runs engine, loads codes
// [RULE2] first long calibration gets initialization period
// [RULE3] later long calibrations get operational period
// [RULE4] short calibration finishes within short period
// [RULE5] controller keeps channel idle during calibration
// [RULE6] controller precharges all banks before calibration
// [RULE7] no self recalibration after self-refresh exit
// [RULE8] controller waits exit delay before calibration
// [RULE9] shared resistor calibrations never overlap
// [RULE10] cke high, data bus released during calibration
// [RULE11] termination held off during calibration; not enforced here, term_en_out ignores cal_busy
// [RULE12] self-refresh or mode disable ignores odt
// [RULE13] termination enabled by any rtt bit
// [RULE14] odt low off, high on unless disabled
// [RULE15] termination ignores read/write command decode
// [RULE16] terminate data pins, strobe pair if enabled
// [RULE17] synchronous timing whenever dll on, locked
// [RULE18] controller disables termination in dll-off mode
// [RULE19] termination follows odt after turn latencies
// [RULE20] latency equals cwl plus al minus two
// [RULE21] controller holds odt four cycles after assertion
// [RULE22] controller holds odt after write with odt
// [RULE23] hold after assertion or short write: four
// [RULE24] hold after long write: six cycles
// [RULE25] controller keeps cke high during calibration
// [RULE26] controller tracks first long calibration issued
//
// Design decisions made here: the APB slave port and the register offsets.
module zqodt_ctrl #(
   parameter int ZQINIT_NCK = zqodt_pkg::ZQINIT_NCK,
   parameter int ZQOPER_NCK = zqodt_pkg::ZQOPER_NCK,
   parameter int ZQCS_NCK = zqodt_pkg::ZQCS_NCK
) (
   input wire logic clk_in, // 100 mhz system clock
   input wire logic rst_in, // async reset, high
   // apb slave
   input wire logic psel, // apb select
   input wire logic penable, // apb access phase
   input wire logic pwrite, // apb write
   input wire logic [7:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error on unmapped address
   // dram pins
   input wire logic ck_in, // memory clock pin
   input wire logic cke_in, // clock enable pin
   input wire logic cs_n_in, // chip select, low
   input wire logic ras_n_in, // row strobe, low
   input wire logic cas_n_in, // column strobe, low
   input wire logic we_n_in, // write enable, low
   input wire logic a10_in, // address bit 10, long vs short
   input wire logic odt_in, // termination control pin
   input wire logic zq_cmp_in, // zq comparator, high when code too weak
   // device status from core logic
   input wire logic self_refresh_in, // device in self-refresh
   input wire logic dll_locked_in, // dll on and locked
   input wire logic banks_open_in, // any bank open
   // io control
   output logic zq_path_en_out, // zq current path enabled
   output logic [5:0] ron_code_out, // driver impedance code
   output logic [5:0] rtt_code_out, // termination impedance code
   output logic term_en_out, // termination on dq, dqs, dm
   output logic tdqs_term_en_out // termination on tdqs pair
);
   // ==========================================
   // pin synchronisers and ck edge detect
   logic [8:0] pin_sync;
   logic ck_s, cke_s, cs_n_s, ras_n_s, cas_n_s, we_n_s, a10_s, odt_s, cmp_s;
   logic ck_prev_reg;
   logic ck_rise;

   zqodt_sync #(.W(9)) u_sync (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .d_in({ck_in, cke_in, cs_n_in, ras_n_in, cas_n_in, we_n_in, a10_in, odt_in, zq_cmp_in}),
      .q_out(pin_sync)
   );

   assign {ck_s, cke_s, cs_n_s, ras_n_s, cas_n_s, we_n_s, a10_s, odt_s, cmp_s} = pin_sync;

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         ck_prev_reg <= 1'b0;
      end else begin
         ck_prev_reg <= ck_s;
      end
   end

   assign ck_rise = ck_s & ~ck_prev_reg;

   // ==========================================
   // registers
   logic [zqodt_pkg::MODE_W-1:0] mode_reg;
   logic [3:0] cwl_reg;
   logic [3:0] al_reg;
   logic wr_en;
   logic rd_en;
   logic [31:0] stat_word;

   assign wr_en = psel & penable & pwrite;
   assign rd_en = psel & penable & ~pwrite;
   // zero wait states, every access ends in its first access cycle
   assign pready = 1'b1;

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         mode_reg <= zqodt_pkg::MODE_RST;
         cwl_reg <= zqodt_pkg::CWL_RST;
         al_reg <= zqodt_pkg::AL_RST;
      end else if (wr_en) begin
         if (paddr == zqodt_pkg::MODE_OFS) begin
            mode_reg <= pwdata[zqodt_pkg::MODE_W-1:0];
         end else if (paddr == zqodt_pkg::LAT_OFS) begin
            cwl_reg <= pwdata[zqodt_pkg::LAT_CWL_LSB +: zqodt_pkg::LAT_FLD_W];
            al_reg <= pwdata[zqodt_pkg::LAT_AL_LSB +: zqodt_pkg::LAT_FLD_W];
         end
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (psel & ~penable) begin
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
         if (paddr == zqodt_pkg::MODE_OFS) begin
            prdata <= {25'h0, mode_reg};
         end else if (paddr == zqodt_pkg::LAT_OFS) begin
            prdata <= {24'h000000, al_reg, cwl_reg};
         end else if (paddr == zqodt_pkg::STAT_OFS) begin
            prdata <= stat_word;
         end else begin
            pslverr <= 1'b1;
         end
      end
   end

   // ==========================================
   // registered command at each ck rising edge
   logic cmd_zq;

   // zq calibration: cs low, ras high, cas high, we low, and cke high
   assign cmd_zq = ck_rise & cke_s & ~cs_n_s & ras_n_s & cas_n_s & ~we_n_s;

   // ==========================================
   // calibration sequencer
   zqodt_pkg::zqodt_cal_t cal_state_reg;
   logic [zqodt_pkg::ZQ_CNT_W-1:0] cal_cnt_reg;
   logic first_done_reg;
   logic [5:0] code_reg;
   logic cal_busy;
   logic cal_last;

   assign cal_busy = (cal_state_reg != zqodt_pkg::ZQ_IDLE);
   assign cal_last = cal_busy & ck_rise & (cal_cnt_reg == '0);

   // commands arriving while busy are ignored; only a command starts a run
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         cal_state_reg <= zqodt_pkg::ZQ_IDLE;
         cal_cnt_reg <= '0;
      end else begin
         case (cal_state_reg)
            zqodt_pkg::ZQ_IDLE: begin
               if (cmd_zq & a10_s) begin
                  cal_state_reg <= zqodt_pkg::ZQ_LONG; // RULE1
                  if (!first_done_reg) begin
                     cal_cnt_reg <= zqodt_pkg::ZQ_CNT_W'(ZQINIT_NCK - 1); // RULE2
                  end else begin
                     cal_cnt_reg <= zqodt_pkg::ZQ_CNT_W'(ZQOPER_NCK - 1); // RULE3
                  end
               end else if (cmd_zq) begin
                  cal_state_reg <= zqodt_pkg::ZQ_SHORT;
                  cal_cnt_reg <= zqodt_pkg::ZQ_CNT_W'(ZQCS_NCK - 1); // RULE4
               end
            end
            zqodt_pkg::ZQ_LONG, zqodt_pkg::ZQ_SHORT: begin
               if (cal_last) begin
                  cal_state_reg <= zqodt_pkg::ZQ_IDLE;
               end else if (ck_rise) begin
                  cal_cnt_reg <= cal_cnt_reg - 1'b1;
               end
            end
            default: begin
               cal_state_reg <= zqodt_pkg::ZQ_IDLE;
            end
         endcase
      end
   end

   // the init period belongs only to the first long run after reset
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         first_done_reg <= 1'b0;
      end else if ((cal_state_reg == zqodt_pkg::ZQ_LONG) & cal_last) begin
         first_done_reg <= 1'b1; // RULE2
      end
   end

   // ==========================================
   // calibration engine: one code step per ck cycle toward the reference
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         code_reg <= zqodt_pkg::CODE_RST;
      end else if (cal_busy & ck_rise) begin
         if (cmp_s & (code_reg != zqodt_pkg::CODE_MAX)) begin
            code_reg <= code_reg + 1'b1; // RULE1
         end else if (~cmp_s & (code_reg != '0)) begin
            code_reg <= code_reg - 1'b1; // RULE1
         end
      end
   end

   // codes reach the io only at the end of a run; self-refresh exit does nothing
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         ron_code_out <= zqodt_pkg::CODE_RST;
         rtt_code_out <= zqodt_pkg::CODE_RST;
      end else if (cal_last) begin
         ron_code_out <= code_reg; // RULE1 RULE7
         rtt_code_out <= code_reg; // RULE1
      end
   end

   // zq current path only while calibrating
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         zq_path_en_out <= 1'b0;
      end else begin
         zq_path_en_out <= cal_busy & ~cal_last;
      end
   end

   // ==========================================
   // power-down tracking
   logic pd_reg;
   // inverted cke as registered at the last ck edge, high while cke was low

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         pd_reg <= 1'b0;
      end else if (ck_rise) begin
         pd_reg <= ~cke_s;
      end
   end

   // ==========================================
   // termination control
   logic rtt_enabled;
   logic sync_mode;
   logic [4:0] lat_sum;
   logic [4:0] odt_tap;
   logic odt_delayed;

   assign rtt_enabled = mode_reg[zqodt_pkg::MODE_NOM_A9] | mode_reg[zqodt_pkg::MODE_NOM_A6] |
                        mode_reg[zqodt_pkg::MODE_NOM_A2] | mode_reg[zqodt_pkg::MODE_WR_A10] |
                        mode_reg[zqodt_pkg::MODE_WR_A9]; // RULE13

   // precharge power-down drops the dll unless the a12 bit keeps it
   assign sync_mode = dll_locked_in & ~self_refresh_in &
                      ~(pd_reg & ~banks_open_in & ~mode_reg[zqodt_pkg::MODE_PPD_A12]); // RULE17

   assign lat_sum = {1'b0, cwl_reg} + {1'b0, al_reg};
   // sums of two or less give no delay
   assign odt_tap = (lat_sum > zqodt_pkg::ODTL_OFFSET) ? (lat_sum - zqodt_pkg::ODTL_OFFSET) : 5'h00; // RULE20

   // pin only, no command decode feeds the line
   zqodt_dline #(.DEPTH(zqodt_pkg::ODT_DEPTH), .TW(zqodt_pkg::TAP_W)) u_dline (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .step_in(ck_rise),
      .d_in(odt_s), // RULE15
      .tap_in(odt_tap), // RULE19
      .q_out(odt_delayed)
   );

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         term_en_out <= 1'b0;
         tdqs_term_en_out <= 1'b0;
      end else begin
         term_en_out <= odt_delayed & rtt_enabled & sync_mode; // RULE12 RULE14 RULE19
         tdqs_term_en_out <= odt_delayed & rtt_enabled & sync_mode &
                             mode_reg[zqodt_pkg::MODE_TDQS_A11]; // RULE16
      end
   end

   // ==========================================
   // status word
   // read only, writes to it are dropped without error
   always_comb begin
      stat_word = 32'h0000_0000;
      stat_word[zqodt_pkg::STAT_BUSY] = cal_busy;
      stat_word[zqodt_pkg::STAT_FIRST] = first_done_reg;
      stat_word[zqodt_pkg::STAT_TERM] = term_en_out;
      stat_word[zqodt_pkg::STAT_SYNC] = sync_mode;
      stat_word[zqodt_pkg::STAT_LONG] = (cal_state_reg == zqodt_pkg::ZQ_LONG);
      stat_word[zqodt_pkg::STAT_CODE_LSB +: zqodt_pkg::CODE_W] = ron_code_out;
   end
endmodule

// file: testbench/zqodt_ctrl_sva.sv
// assertions on the zq calibration and odt control ports
module zqodt_ctrl_sva #(
   parameter int ZQINIT_NCK = 512
) (
   input wire logic clk_in, // clock
   input wire logic rst_in, // reset
   input wire logic psel, // apb select
   input wire logic penable, // apb access
   input wire logic [7:0] paddr, // apb address
   input wire logic pready, // apb ready
   input wire logic pslverr, // apb error
   input wire logic self_refresh_in, // self-refresh
   input wire logic dll_locked_in, // dll locked
   input wire logic zq_path_en_out, // calibrating
   input wire logic [5:0] ron_code_out, // driver code
   input wire logic [5:0] rtt_code_out, // termination code
   input wire logic term_en_out, // termination on
   input wire logic tdqs_term_en_out // tdqs termination
);
   timeunit 1ns;
   timeprecision 1ps;
   int run_cnt;
   // ==========================================
   // run length counter
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         run_cnt <= 0;
      end else begin
         run_cnt <= zq_path_en_out ? run_cnt + 1 : 0;
      end
   end
   // ==========================================
   // properties
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);
   sequence run_end;
      $fell(zq_path_en_out);
   endsequence
   ready_high_a: assert property (pready) else $error("pready low");
   code_pair_a: assert property (ron_code_out == rtt_code_out) else $error("codes differ");
   code_load_a: assert property ($changed(ron_code_out) |-> run_end)
      else $error("code changed outside a run end");
   run_min_a: assert property ($rose(zq_path_en_out) |-> zq_path_en_out[*8])
      else $error("run too short");
   run_len_a: assert property (run_cnt <= (ZQINIT_NCK + 1) * 16 + 8) else $error("run too long");
   tdqs_sub_a: assert property (tdqs_term_en_out |-> term_en_out) else $error("tdqs without term");
   self_ref_a: assert property (self_refresh_in |=> !term_en_out) else $error("term in self-refresh");
   dll_off_a: assert property (!dll_locked_in |=> !term_en_out) else $error("term with dll off");
   unmapped_a: assert property (psel && penable && paddr > 8'h08 |-> pslverr) else $error("no slave error");
endmodule

// file: testbench/zqodt_ctrl_host.sv
// memory controller model driving ck, command and odt pins
module zqodt_ctrl_host (
   input wire logic clk_in, // system clock
   output logic ck_out, // memory clock, free running
   output logic cke_out, // clock enable
   output logic cs_n_out, // chip select, low
   output logic ras_n_out, // row strobe, low
   output logic cas_n_out, // column strobe, low
   output logic we_n_out, // write enable, low
   output logic a10_out, // long or short select
   output logic odt_out // termination control
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      ck_out = 1'b0;
      cke_out = 1'b1;
      {cs_n_out, ras_n_out, cas_n_out, we_n_out, a10_out, odt_out} = 6'b111110;
      #3;
      forever #80 ck_out = ~ck_out;
   end
   // pins move after a ck fall, on a clk rise
   task automatic drive(input logic [4:0] cmd);
      @(negedge ck_out);
      @(posedge clk_in);
      {cs_n_out, ras_n_out, cas_n_out, we_n_out, a10_out} <= cmd;
      @(posedge ck_out);
   endtask
   // sent with banks precharged and the channel idle, except the second command of a pair, sent during a run
   task automatic zq_cmd(input logic lng);
      drive({4'b0110, lng});
      @(negedge ck_out);
      @(posedge clk_in);
      {cs_n_out, ras_n_out, cas_n_out, we_n_out, a10_out} <= {4'b1001, ~lng};
   endtask
   // odt low during runs, high spells of six ck or more, no writes
   task automatic set_odt(input logic v);
      @(negedge ck_out);
      @(posedge clk_in);
      odt_out <= v;
      @(posedge ck_out);
   endtask
   // cke moves after a ck fall, never during a run
   task automatic set_cke(input logic v);
      @(negedge ck_out);
      @(posedge clk_in);
      cke_out <= v;
      @(posedge ck_out);
   endtask
endmodule

// file: testbench/zqodt_ctrl_tb.sv
// testbench for the zq calibration and odt control block
module zqodt_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int INIT_N = 8;
   localparam int OPER_N = 6;
   localparam int SHORT_N = 4;
   logic clk_in, rst_in, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic ck_in, cke_in, cs_n_in, ras_n_in, cas_n_in, we_n_in, a10_in, odt_in;
   logic zq_cmp_in, self_refresh_in, dll_locked_in, banks_open_in;
   logic zq_path_en_out, term_en_out, tdqs_term_en_out;
   logic [5:0] ron_code_out, rtt_code_out, c0;
   logic long_sent;
   int failures, check_count, n;
   zqodt_ctrl #(.ZQINIT_NCK(INIT_N), .ZQOPER_NCK(OPER_N), .ZQCS_NCK(SHORT_N)) u_dut (.clk_in, .rst_in,
      .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .ck_in, .cke_in, .cs_n_in,
      .ras_n_in, .cas_n_in, .we_n_in, .a10_in, .odt_in, .zq_cmp_in, .self_refresh_in, .dll_locked_in,
      .banks_open_in, .zq_path_en_out, .ron_code_out, .rtt_code_out, .term_en_out, .tdqs_term_en_out);
   zqodt_ctrl_host u_host (.clk_in, .ck_out(ck_in), .cke_out(cke_in), .cs_n_out(cs_n_in),
      .ras_n_out(ras_n_in), .cas_n_out(cas_n_in), .we_n_out(we_n_in), .a10_out(a10_in), .odt_out(odt_in));
   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_in);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_in);
      penable <= 1'b1;
      do begin
         @(posedge clk_in);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %0t flag got %b expected %b", $time, got, exp);
      end
   endtask
   // counts ck edges from the command to the end of the run
   task automatic zq_run(input logic lng, input int exp_n, input logic twice);
      u_host.zq_cmd(lng);
      if (lng) long_sent = 1'b1;
      if (twice) u_host.zq_cmd(1'b0);
      n = twice ? 2 : 0;
      while (n < 600) begin
         @(posedge ck_in);
         #60;
         n++;
         if (zq_path_en_out === 1'b0) break;
      end
      chk(n, exp_n);
   endtask
   task automatic tally_and_finish();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   initial begin
      #200us;
      failures++;
      tally_and_finish();
   end
   initial begin
      {psel, penable, pwrite, paddr, pwdata, zq_cmp_in, self_refresh_in, banks_open_in} = '0;
      dll_locked_in = 1'b1;
      failures = 0;
      check_count = 0;
      long_sent = 1'b0;
      rst_in = 1'b1;
      repeat (6) @(posedge clk_in);
      rst_in <= 1'b0;
      apb(1'b0, zqodt_pkg::MODE_OFS, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, zqodt_pkg::LAT_OFS, 32'h0);
      chk(rd, 32'h05);
      apb(1'b1, zqodt_pkg::STAT_OFS, 32'hffff);
      apb(1'b0, zqodt_pkg::STAT_OFS, 32'h0);
      chk(rd, 32'h2008);
      apb(1'b0, 8'h0c, 32'h0);
      chk(rd, 32'h0);
      chk_bit(err, 1'b1);
      zq_cmp_in <= 1'b1;
      zq_run(1'b1, long_sent ? OPER_N : INIT_N, 1'b0);
      chk_bit(ron_code_out > 6'h20, 1'b1);
      apb(1'b0, zqodt_pkg::STAT_OFS, 32'h0);
      chk_bit(rd[1], 1'b1);
      zq_run(1'b1, long_sent ? OPER_N : INIT_N, 1'b1);
      @(posedge clk_in);
      zq_cmp_in <= 1'b0;
      c0 = ron_code_out;
      zq_run(1'b0, SHORT_N, 1'b0);
      chk_bit(ron_code_out < c0, 1'b1);
      apb(1'b1, zqodt_pkg::LAT_OFS, 32'h35);
      apb(1'b1, zqodt_pkg::MODE_OFS, 32'h21);
      for (int v = 1; v >= 0; v--) begin
         u_host.set_odt(v[0]);
         repeat (5) @(posedge ck_in);
         #60;
         chk_bit(term_en_out, !v[0]);
         @(posedge ck_in);
         #60;
         chk({30'h0, term_en_out, tdqs_term_en_out}, {30'h0, {2{v[0]}}});
      end
      u_host.set_odt(1'b1);
      repeat (7) @(posedge ck_in);
      for (int i = 0; i < 6; i++) begin
         apb(1'b1, zqodt_pkg::MODE_OFS, 32'h1 << i);
         repeat (2) @(posedge clk_in);
         chk_bit(term_en_out, i < 5);
      end
      apb(1'b1, zqodt_pkg::MODE_OFS, 32'h1);
      self_refresh_in <= 1'b1;
      repeat (2) @(posedge clk_in);
      chk_bit(term_en_out, 1'b0);
      self_refresh_in <= 1'b0;
      dll_locked_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      chk_bit(term_en_out, 1'b0);
      dll_locked_in <= 1'b1;
      repeat (2) @(posedge clk_in);
      chk_bit(term_en_out, 1'b1);
      u_host.set_cke(1'b0);
      #60;
      chk_bit(term_en_out, 1'b0);
      apb(1'b1, zqodt_pkg::MODE_OFS, 32'h41);
      repeat (2) @(posedge clk_in);
      chk_bit(term_en_out, 1'b1);
      apb(1'b1, zqodt_pkg::MODE_OFS, 32'h1);
      banks_open_in <= 1'b1;
      repeat (2) @(posedge clk_in);
      chk_bit(term_en_out, 1'b1);
      u_host.set_cke(1'b1);
      u_host.set_odt(1'b0);
      c0 = ron_code_out;
      repeat (8) @(posedge ck_in);
      chk({25'h0, zq_path_en_out, ron_code_out}, {25'h0, 1'b0, c0});
      tally_and_finish();
   end
endmodule
bind zqodt_ctrl zqodt_ctrl_sva #(.ZQINIT_NCK(ZQINIT_NCK)) u_sva (.clk_in, .rst_in, .psel, .penable, .paddr,
   .pready, .pslverr, .self_refresh_in, .dll_locked_in, .zq_path_en_out, .ron_code_out, .rtt_code_out,
   .term_en_out, .tdqs_term_en_out);
